// ===== hw/fault_monitor_consts.vh
// constants for the drive fault and error monitor
// assumes a 32-bit apb register bus on pclk
`ifndef FAULT_MONITOR_CONSTS_VH
`define FAULT_MONITOR_CONSTS_VH
`define FM_ADDR_CTRL      12'h000
`define FM_ADDR_LATCH_EN  12'h004
`define FM_ADDR_CLEAR     12'h008
`define FM_ADDR_STATUS    12'h00C
`define FM_ADDR_LAG_TRIP  12'h010
`define FM_ADDR_LAG_WARN  12'h014
`define FM_ADDR_PWIN      12'h018
`define FM_ADDR_PTIME     12'h01C
`define FM_ADDR_VWIN      12'h020
`define FM_ADDR_VTIME     12'h024
`define FM_ADDR_POS_ERR   12'h028
`define FM_ADDR_VEL_ERR   12'h02C
`define FM_ADDR_LOG       12'h030
`define FM_ADDR_ACTIVE    12'h034
`define FM_F_DRV_OT       0
`define FM_F_PHASE        1
`define FM_F_FEEDBACK     2
`define FM_F_MOT_OT       3
`define FM_F_UNDER_V      4
`define FM_F_OVER_V       5
`define FM_F_LAG          6
`define FM_F_SHORT        7
`define FM_F_OVER_I       8
`define FM_NFAULT         9
`define FM_LATCH_RST      9'h0CD
`define FM_CTRL_RST       32'h0000_0000
`define FM_CTRL_LAG_EN    0
`define FM_CTRL_NET_MODE  1
`define FM_CTRL_HALL_COR  2
`define FM_CTRL_SW_EN     3
`define FM_ST_WARN        0
`define FM_ST_LAG         1
`define FM_ST_PTRACK      2
`define FM_ST_VTRACK      3
`define FM_ST_FAULT       4
`define FM_ST_LATCHED     5
`define FM_ST_PWM_EN      6
`define FM_ST_FASTSTOP    7
`endif

// ===== hw/fault_monitor.v
// drive fault supervision, position-lag trip/warning, tracking windows
// assumes synchronous condition inputs from the drive core except pins
//
// Decided for this implementation: the address map and register access over APB.
`include "fault_monitor_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module track_window #(
    parameter W = 32
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] err,
    input  wire [W-1:0] window,
    input  wire [31:0]  hold_cycles,
    output reg          tracking_q
);
    reg  [31:0]  cnt_q;
    wire [W-1:0] mag;
    wire         outside;
    assign mag     = err[W-1] ? (~err + 1'b1) : err;
    assign outside = mag > window;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tracking_q <= 1'b0;
            cnt_q      <= 32'h0000_0000;
        end
        else if (outside)
        begin
            tracking_q <= 1'b1;
            cnt_q      <= 32'h0000_0000;
        end
        else if (tracking_q)
        begin
            if (cnt_q + 32'h0000_0001 >= hold_cycles)
                tracking_q <= 1'b0;
            else
                cnt_q <= cnt_q + 32'h0000_0001;
        end
        else
            cnt_q <= 32'h0000_0000;
    end
endmodule

module fault_monitor #(
    parameter W = 32
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [11:0]  paddr,
    input  wire [31:0]  pwdata,
    output wire [31:0]  prdata,
    output wire         pready,
    output wire         pslverr,
    input  wire         drv_temp_over,
    input  wire         hall_mismatch,
    input  wire         sine_brushless,
    input  wire         resolver_fb,
    input  wire         fb_supply_overcur,
    input  wire         fb_signal_bad,
    input  wire         motor_temp_pin,
    input  wire         bus_under,
    input  wire         bus_over,
    input  wire         short_detect,
    input  wire         i2t_over,
    input  wire         enable_pin,
    input  wire         enable_clears,
    input  wire         new_trajectory,
    input  wire [W-1:0] traj_pos,
    input  wire [W-1:0] motor_pos,
    input  wire [W-1:0] vel_cmd,
    input  wire [W-1:0] motor_vel,
    output reg          pwm_enable_q,
    output reg          fast_stop_q,
    output reg          lag_warn_q,
    output reg          fault_q,
    output reg          log_strobe_q,
    output reg  [3:0]   log_code_q
);
    localparam N = `FM_NFAULT;
    localparam H = 4;

    // configuration and fault state
    reg  [31:0]  ctrl_q;
    reg  [N-1:0] latch_en_q;
    reg  [N-1:0] active_q;
    reg  [N-1:0] was_latched_q;
    reg  [W-1:0] lag_trip_q;
    reg  [W-1:0] lag_warn_lvl_q;
    reg  [W-1:0] pwin_q;
    reg  [W-1:0] vwin_q;
    reg  [31:0]  ptime_q;
    reg  [31:0]  vtime_q;
    reg  [W-1:0] pos_err_q;
    reg  [W-1:0] vel_err_q;
    reg  [31:0]  rdata_q;
    reg  [3:0]   hist_q [0:H-1];

    // pin synchronisers
    reg          mot_s1_q;
    reg          mot_s2_q;
    reg          en_s1_q;
    reg          en_s2_q;
    reg          en_dly_q;

    // combinational fault decode
    reg  [N-1:0] cond;
    reg  [N-1:0] latch_eff;
    reg  [N-1:0] clr_ev;
    reg  [3:0]   code_d;
    wire         wr;
    wire         rd;
    wire         en_now;
    wire         en_rise;
    wire         en_fall;
    wire         host_clr;
    wire [W-1:0] pos_mag;
    wire         ptrack;
    wire         vtrack;
    wire [N-1:0] soft_mask;
    wire         stage_block;
    wire [31:0]  status_w;
    wire [31:0]  log_w;
    integer      i;
    integer      j;

    // apb strobes, no wait states
    assign wr      = psel & penable & pwrite;
    assign rd      = psel & ~penable & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = rdata_q;
    assign en_now  = en_s2_q & ctrl_q[`FM_CTRL_SW_EN];
    assign en_rise = en_now & ~en_dly_q;
    assign en_fall = ~en_now & en_dly_q;
    assign host_clr = wr && paddr == `FM_ADDR_CLEAR && pwdata[0];
    assign pos_mag = pos_err_q[W-1] ? (~pos_err_q + 1'b1) : pos_err_q;
    // only a non-latched lag trip leaves the stage on
    assign soft_mask   = {{(N-7){1'b0}}, 1'b1, 6'h00} & ~was_latched_q;
    assign stage_block = |(active_q & ~soft_mask);
    assign status_w = {
        24'h00_0000,
        fast_stop_q,
        pwm_enable_q,
        |(active_q & was_latched_q),
        fault_q,
        vtrack,
        ptrack,
        active_q[`FM_F_LAG],
        lag_warn_q
    };
    assign log_w = {16'h0000, hist_q[3], hist_q[2], hist_q[1], hist_q[0]};

    // condition sources
    always @*
    begin
        cond = {N{1'b0}};
        cond[`FM_F_DRV_OT]   = drv_temp_over;
        cond[`FM_F_PHASE]    = hall_mismatch & sine_brushless &
                               ~resolver_fb &
                               ctrl_q[`FM_CTRL_HALL_COR];
        cond[`FM_F_FEEDBACK] = fb_supply_overcur | fb_signal_bad;
        cond[`FM_F_MOT_OT]   = mot_s2_q;
        cond[`FM_F_UNDER_V]  = bus_under;
        cond[`FM_F_OVER_V]   = bus_over;
        cond[`FM_F_LAG]      = ctrl_q[`FM_CTRL_LAG_EN] &
                               (pos_mag >= lag_trip_q);
        cond[`FM_F_SHORT]    = short_detect;
        cond[`FM_F_OVER_I]   = i2t_over;
        // velocity error feeds no fault source
        latch_eff = latch_en_q;
        latch_eff[`FM_F_OVER_I] = 1'b1;
        code_d = 4'h0;
        for (i = N - 1; i >= 0; i = i - 1)
            if (cond[i] & ~active_q[i])
                code_d = i[3:0] + 4'h1;
        // clear events: corrected condition alone when non-latched, plus a valid trigger when latched or for lag
        for (i = 0; i < N; i = i + 1)
            clr_ev[i] = latch_eff[i] ? (host_clr | (en_rise & enable_clears))
                                     : ~cond[i];
        clr_ev[`FM_F_OVER_I] = host_clr | en_rise;
        if (!latch_eff[`FM_F_LAG])
            clr_ev[`FM_F_LAG] = ctrl_q[`FM_CTRL_NET_MODE] ? new_trajectory
                              : en_rise;
    end

    // position tracking window
    track_window #(.W(W)) u_ptrack (
        .pclk        (pclk),
        .presetn     (presetn),
        .err         (pos_err_q),
        .window      (pwin_q),
        .hold_cycles (ptime_q),
        .tracking_q  (ptrack)
    );
    // velocity tracking window
    track_window #(.W(W)) u_vtrack (
        .pclk        (pclk),
        .presetn     (presetn),
        .err         (vel_err_q),
        .window      (vwin_q),
        .hold_cycles (vtime_q),
        .tracking_q  (vtrack)
    );

    // pin synchronisers, two flops each
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mot_s1_q <= 1'b0;
            mot_s2_q <= 1'b0;
            en_s1_q  <= 1'b0;
            en_s2_q  <= 1'b0;
            en_dly_q <= 1'b0;
        end
        else
        begin
            mot_s1_q <= motor_temp_pin;
            mot_s2_q <= mot_s1_q;
            en_s1_q  <= enable_pin;
            en_s2_q  <= en_s1_q;
            en_dly_q <= en_now;
        end
    end

    // registered position and velocity errors
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pos_err_q  <= {W{1'b0}};
            vel_err_q  <= {W{1'b0}};
            lag_warn_q <= 1'b0;
        end
        else
        begin
            pos_err_q  <= traj_pos - motor_pos;
            vel_err_q  <= vel_cmd - motor_vel;
            lag_warn_q <= pos_mag >= lag_warn_lvl_q;
        end
    end

    // configuration writes, taken in the access phase
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q         <= `FM_CTRL_RST;
            latch_en_q     <= `FM_LATCH_RST;
            lag_trip_q     <= {W{1'b1}};
            lag_warn_lvl_q <= {W{1'b1}};
            pwin_q         <= {W{1'b1}};
            vwin_q         <= {W{1'b1}};
            ptime_q        <= 32'h0000_0000;
            vtime_q        <= 32'h0000_0000;
        end
        else if (wr)
        begin
            case (paddr)
                `FM_ADDR_CTRL:     ctrl_q <= pwdata;
                `FM_ADDR_LATCH_EN: latch_en_q <= pwdata[N-1:0];
                `FM_ADDR_LAG_TRIP: lag_trip_q <= pwdata[W-1:0];
                `FM_ADDR_LAG_WARN: lag_warn_lvl_q <= pwdata[W-1:0];
                `FM_ADDR_PWIN:     pwin_q <= pwdata[W-1:0];
                `FM_ADDR_PTIME:    ptime_q <= pwdata;
                `FM_ADDR_VWIN:     vwin_q <= pwdata[W-1:0];
                `FM_ADDR_VTIME:    vtime_q <= pwdata;
                default:           ctrl_q <= ctrl_q;
            endcase
        end
    end

    // read data loaded in the setup cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_q <= 32'h0000_0000;
        else if (rd)
        begin
            case (paddr)
                `FM_ADDR_CTRL:     rdata_q <= ctrl_q;
                `FM_ADDR_LATCH_EN: rdata_q <= {23'h0, latch_en_q};
                `FM_ADDR_STATUS:   rdata_q <= status_w;
                `FM_ADDR_LAG_TRIP: rdata_q <= lag_trip_q;
                `FM_ADDR_LAG_WARN: rdata_q <= lag_warn_lvl_q;
                `FM_ADDR_PWIN:     rdata_q <= pwin_q;
                `FM_ADDR_PTIME:    rdata_q <= ptime_q;
                `FM_ADDR_VWIN:     rdata_q <= vwin_q;
                `FM_ADDR_VTIME:    rdata_q <= vtime_q;
                `FM_ADDR_POS_ERR:  rdata_q <= pos_err_q;
                `FM_ADDR_VEL_ERR:  rdata_q <= vel_err_q;
                `FM_ADDR_LOG:      rdata_q <= log_w;
                `FM_ADDR_ACTIVE:   rdata_q <= {23'h0, active_q};
                default:           rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // fault flags, stage control and error log
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active_q      <= {N{1'b0}};
            was_latched_q <= {N{1'b0}};
            pwm_enable_q  <= 1'b0;
            fast_stop_q   <= 1'b0;
            fault_q       <= 1'b0;
            log_strobe_q  <= 1'b0;
            log_code_q    <= 4'h0;
            for (j = 0; j < H; j = j + 1)
                hist_q[j] <= 4'h0;
        end
        else
        begin
            for (j = 0; j < N; j = j + 1)
            begin
                // set wins over clear
                if (cond[j])
                begin
                    active_q[j]      <= 1'b1;
                    was_latched_q[j] <= latch_eff[j];
                end
                else if (active_q[j] & clr_ev[j])
                    active_q[j] <= 1'b0;
            end
            log_strobe_q <= code_d != 4'h0;
            if (code_d != 4'h0)
            begin
                log_code_q <= code_d;
                hist_q[0]  <= code_d;
                for (j = 1; j < H; j = j + 1)
                    hist_q[j] <= hist_q[j-1];
            end
            fault_q <= |active_q;
            // lag non-latched keeps stage on with fast stop
            fast_stop_q <= active_q[`FM_F_LAG] &
                           ~was_latched_q[`FM_F_LAG];
            pwm_enable_q <= en_now & ~en_fall &
                            ~stage_block;
        end
    end
endmodule
`default_nettype wire

// ===== test/fm_far.sv
// far side model: fault sensors and host trajectory pulses
// assumes the bench asks for condition levels on pclk
`timescale 1ns/1ns
`default_nettype none
module fm_far (
    input  wire logic       pclk,
    input  wire logic [8:0] flt,
    input  wire logic       traj,
    output logic      [8:0] cond_q,
    output logic            newtraj_q
);
    always @(posedge pclk)
    begin
        cond_q <= flt;
        // host issues a new trajectory as one pulse
        newtraj_q <= traj & ~newtraj_q;
    end
endmodule
`default_nettype wire

// ===== test/fault_monitor_assertions.sv
// checker on the fault monitor ports
// assumes one clock domain, pclk with async presetn
`timescale 1ns/1ns
`default_nettype none
module fault_monitor_assertions (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       drv_temp_over,
    input wire logic       fb_supply_overcur,
    input wire logic       motor_temp_pin,
    input wire logic       bus_under,
    input wire logic       bus_over,
    input wire logic       short_detect,
    input wire logic       i2t_over,
    input wire logic       pwm_enable_q,
    input wire logic       fast_stop_q,
    input wire logic       fault_q,
    input wire logic       log_strobe_q,
    input wire logic [3:0] log_code_q
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    drv_hot_a: assert property (drv_temp_over |-> ##[1:6] fault_q)
        else $error("drive overtemp without fault");
    fb_bad_a: assert property (fb_supply_overcur |-> ##[1:6] fault_q)
        else $error("feedback supply without fault");
    motor_hot_a: assert property (motor_temp_pin |-> ##[1:8] fault_q)
        else $error("motor overtemp without fault");
    bus_volt_a: assert property ((bus_under || bus_over) |-> ##[1:6] fault_q)
        else $error("bus voltage without fault");
    short_flt_a: assert property (short_detect |-> ##[1:6] fault_q)
        else $error("short without fault");
    over_cur_a: assert property (i2t_over |-> ##[1:6] (fault_q && !pwm_enable_q))
        else $error("overcurrent left stage on");
    stage_off_a: assert property (fault_q && !fast_stop_q |-> !pwm_enable_q)
        else $error("stage on during fault");
    fast_stop_a: assert property ($rose(fast_stop_q) |-> ##[0:2] fault_q)
        else $error("fast stop without trip");
    log_code_a: assert property (log_strobe_q |-> log_code_q inside {[1:9]})
        else $error("log code out of range");
endmodule
bind fault_monitor fault_monitor_assertions chk_u (.pclk(pclk), .presetn(presetn),
    .drv_temp_over(drv_temp_over), .fb_supply_overcur(fb_supply_overcur),
    .motor_temp_pin(motor_temp_pin), .bus_under(bus_under), .bus_over(bus_over),
    .short_detect(short_detect), .i2t_over(i2t_over), .fault_q(fault_q),
    .pwm_enable_q(pwm_enable_q), .fast_stop_q(fast_stop_q),
    .log_strobe_q(log_strobe_q), .log_code_q(log_code_q));
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the fault monitor
// assumes apb master here and the far side model in fm_far
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rv, tp = 0, mp = 0, vc = 0, mv = 0;
    logic pready, pslverr, en = 0, tr = 0, pwm, fs, wn, fq, ls, nt;
    logic sb = 0, rf = 0, ec = 0;
    logic [3:0] lc;
    logic [8:0] flt = 0, c;
    int err_count = 0, checks = 0, cyc = 0;
    always #10 pclk = ~pclk;
    fm_far far_u (.pclk(pclk), .flt(flt), .traj(tr), .cond_q(c), .newtraj_q(nt));
    fault_monitor dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .drv_temp_over(c[0]), .hall_mismatch(c[1]), .sine_brushless(sb),
        .resolver_fb(rf), .fb_supply_overcur(c[2]), .fb_signal_bad(c[6]),
        .motor_temp_pin(c[3]), .bus_under(c[4]), .bus_over(c[5]),
        .short_detect(c[7]), .i2t_over(c[8]), .enable_pin(en),
        .enable_clears(ec), .new_trajectory(nt), .traj_pos(tp),
        .motor_pos(mp), .vel_cmd(vc), .motor_vel(mv), .pwm_enable_q(pwm),
        .fast_stop_q(fs), .lag_warn_q(wn), .fault_q(fq), .log_strobe_q(ls),
        .log_code_q(lc));
    task summarize;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task ck(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task w8;
        repeat (8) @(posedge pclk);
    endtask
    task t_reset;
        apb(0, 12'h004, 0); ck("latch_en", 32'h0000_00CD, rv);
        apb(0, 12'h3FC, 0); ck("unmapped", 32'h0000_0000, rv);
        ck("slverr", 0, pslverr);
        apb(1, 12'h000, 32'h0000_0008); en <= 1; w8;
        ck("pwm", 1, pwm);
        $display("reset test done");
    endtask
    task t_faults;
        flt <= 9'h002; w8; ck("phase", 0, fq);
        sb <= 1; apb(1, 12'h000, 32'h0000_000C);
        w8; ck("phase", 1, fq); ck("code", 2, lc);
        flt <= 0; w8; ck("phase clr", 0, fq);
        rf <= 1; flt <= 9'h002; w8; ck("resolver", 0, fq);
        rf <= 0; flt <= 0; apb(1, 12'h000, 32'h0000_0008);
        flt <= 9'h001; w8; ck("ot", 1, fq); ck("code", 1, lc);
        ck("pwm", 0, pwm);
        flt <= 0; w8; ck("held", 1, fq);
        apb(1, 12'h008, 1); w8; ck("clr", 0, fq); ck("on", 1, pwm);
        flt <= 9'h010; w8; ck("uv", 5, lc); flt <= 0; w8;
        ck("auto", 0, fq); ck("re", 1, pwm);
        flt <= 9'h100; w8; flt <= 0; w8; ck("oc", 9, lc);
        ck("oc pwm", 0, pwm);
        en <= 0; w8; en <= 1; w8; ck("oc clr", 0, fq);
        apb(0, 12'h030, 0); ck("log", 32'h0000_2159, rv);
        $display("fault test done");
    endtask
    task t_lag;
        apb(1, 12'h010, 100); apb(1, 12'h014, 50);
        apb(1, 12'h004, 32'h0000_008D); apb(1, 12'h000, 32'h0000_000B);
        tp <= 60; w8; ck("warn", 1, wn); ck("nf", 0, fq);
        apb(0, 12'h028, 0); ck("perr", 60, rv);
        tp <= 100; w8; ck("trip", 1, fq); ck("fs", 1, fs);
        ck("pwm", 1, pwm); ck("code", 7, lc);
        apb(0, 12'h00C, 0); ck("st", 1, rv[1]);
        tp <= 0; tr <= 1; @(posedge pclk); tr <= 0; w8;
        ck("resume", 0, fq); ck("fs", 0, fs);
        apb(1, 12'h000, 32'h0000_0009);
        tp <= 100; w8; ck("trip in", 1, fq);
        tp <= 0; w8; ck("held in", 1, fq);
        en <= 0; w8; en <= 1; w8; ck("re-en", 0, fq);
        ec <= 1; apb(1, 12'h004, 32'h0000_00CD);
        tp <= 100; w8; ck("hard", 1, fq); ck("off", 0, pwm);
        ck("no fs", 0, fs);
        tp <= 0; w8; ck("hard held", 1, fq);
        en <= 0; w8; en <= 1; w8; ck("ec clr", 0, fq);
        ck("on", 1, pwm);
        ec <= 0; apb(1, 12'h004, 32'h0000_008D);
        $display("lag test done");
    endtask
    task t_vel;
        vc <= 32'h7FFF_0000; w8; ck("vel", 0, fq);
        apb(1, 12'h020, 10); apb(1, 12'h024, 20);
        vc <= 20; w8; apb(0, 12'h00C, 0); ck("vt", 1, rv[3]);
        vc <= 0; w8; apb(0, 12'h00C, 0); ck("hold", 1, rv[3]);
        repeat (30) @(posedge pclk);
        apb(0, 12'h00C, 0); ck("vclr", 0, rv[3]);
        apb(1, 12'h018, 10); apb(1, 12'h01C, 4);
        tp <= 20; w8; apb(0, 12'h00C, 0); ck("pt", 1, rv[2]);
        tp <= 0; repeat (12) @(posedge pclk);
        apb(0, 12'h00C, 0); ck("ptclr", 0, rv[2]);
        $display("velocity test done");
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            summarize();
        end
    end
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        t_reset;
        t_faults;
        t_lag;
        t_vel;
        summarize();
    end
endmodule
`default_nettype wire
